// File: logic/uie_core.sv
`timescale 1ns/1ns
`include "uie_consts.svh"
// --------------------------------
// interrupt enable and identification
// --------------------------------
module uie_core
    import uie_pkg::*;
#(
    parameter int MODEM_W = `UIE_MODEM_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic dlab,
    input wire logic line_err,
    input wire logic rx_ready,
    input wire logic rx_timeout,
    input wire logic tx_empty,
    input wire logic [MODEM_W-1:0] modem_in,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic [7:0] fifo_control_reg,
    output logic fifo_ctl_wr,
    output logic irq
);
    // --------------------------------
    // state
    // --------------------------------
    logic [3:0] en_q, en_d;
    logic fifo_on_status_q, fifo_on_status_d;
    logic [7:0] fctl_q, fctl_d;
    logic fctl_wr_q, fctl_wr_d;
    logic modem_pend_q, modem_pend_d;
    logic line_pend_q, line_pend_d;
    logic line_prev_q, line_prev_d;
    logic tx_pend_q, tx_pend_d;
    logic tx_prev_q, tx_prev_d;
    logic [MODEM_W-1:0] modem_prev_q, modem_prev_d;
    logic [MODEM_W-1:0] modem_sync;
    logic [7:0] ident_q, ident_d;
    logic irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    // --------------------------------
    // modem input synchroniser
    // --------------------------------
    uie_sync #(
        .W(MODEM_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(modem_in),
        .q(modem_sync)
    );
    // --------------------------------
    // decode
    // --------------------------------
    logic wr_en_reg, wr_ident, wr_thr, rd_lsr, rd_msr, rd_ident, rd_en_reg;
    assign wr_en_reg = wr_en && !dlab && (addr == `UIE_ADDR_DIV_HIGH);
    assign wr_ident = wr_en && (addr == `UIE_ADDR_IDENT);
    assign wr_thr = wr_en && !dlab && (addr == `UIE_ADDR_TX_HOLD);
    assign rd_lsr = rd_en && (addr == `UIE_ADDR_LINE_STAT);
    assign rd_msr = rd_en && (addr == `UIE_ADDR_MODEM_STAT);
    assign rd_ident = rd_en && (addr == `UIE_ADDR_IDENT);
    assign rd_en_reg = rd_en && !dlab && (addr == `UIE_ADDR_DIV_HIGH);
    // --------------------------------
    // enable and fifo control
    // --------------------------------
    always_comb
    begin
        en_d = en_q;
        fctl_d = fctl_q;
        fctl_wr_d = 1'b0;
        fifo_on_status_d = fifo_on_status_q;
        if (wr_en_reg)
        begin
            en_d = wdata[`UIE_EN_MSB:0];
        end
        if (wr_ident)
        begin
            fctl_d = wdata;
            fctl_wr_d = 1'b1;
            fifo_on_status_d = wdata[`UIE_FIFO_EN_BIT];
        end
    end
    // --------------------------------
    // modem edge detect
    // --------------------------------
    logic [MODEM_W-1:0] modem_chg;
    genvar g;
    generate
        for (g = 0; g < MODEM_W; g++)
        begin : g_chg
            assign modem_chg[g] = modem_sync[g] ^ modem_prev_q[g];
        end
    endgenerate
    always_comb
    begin
        modem_prev_d = modem_sync;
        modem_pend_d = modem_pend_q;
        if (rd_msr)
        begin
            modem_pend_d = 1'b0;
        end
        if (|modem_chg)
        begin
            modem_pend_d = 1'b1; // set wins over clear
        end
    end
    // --------------------------------
    // line error pending
    // --------------------------------
    always_comb
    begin
        line_prev_d = line_err;
        line_pend_d = line_pend_q;
        if (rd_lsr)
        begin
            line_pend_d = 1'b0;
        end
        if (line_err && !line_prev_q)
        begin
            line_pend_d = 1'b1;
        end
    end
    // --------------------------------
    // transmit empty pending
    // --------------------------------
    always_comb
    begin
        tx_prev_d = tx_empty;
        tx_pend_d = tx_pend_q;
        if (wr_thr)
        begin
            tx_pend_d = 1'b0;
        end
        if (tx_empty && !tx_prev_q)
        begin
            tx_pend_d = 1'b1;
        end
    end
    // --------------------------------
    // gated sources
    // --------------------------------
    logic src_line, src_rx, src_to, src_tx, src_modem;
    assign src_line = line_pend_q && en_q[`UIE_EN_LINE];
    assign src_rx = rx_ready && en_q[`UIE_EN_RX];
    assign src_to = rx_timeout && en_q[`UIE_EN_RX];
    assign src_tx = tx_pend_q && tx_empty && en_q[`UIE_EN_TX];
    assign src_modem = modem_pend_q && en_q[`UIE_EN_MODEM];
    // --------------------------------
    // identification
    // --------------------------------
    always_comb
    begin
        uie_code_t irq_source_code;
        logic irq_pending_n;
        logic [1:0] fifo_bits;
        fifo_bits = fifo_on_status_q ? `UIE_FIFO_ON : `UIE_FIFO_OFF;
        irq_source_code = `UIE_CODE_MODEM;
        irq_pending_n = 1'b0;
        if (src_line)
        begin
            irq_source_code = `UIE_CODE_LINE;
        end
        else if (src_rx)
        begin
            irq_source_code = `UIE_CODE_RXDATA;
        end
        else if (src_to)
        begin
            irq_source_code = `UIE_CODE_TIMEOUT;
        end
        else if (src_tx)
        begin
            irq_source_code = `UIE_CODE_TXEMPTY;
        end
        else if (src_modem)
        begin
            irq_source_code = `UIE_CODE_MODEM;
        end
        else
        begin
            irq_pending_n = 1'b1;
        end
        ident_d = {fifo_bits, `UIE_RSVD_IDENT, irq_source_code, irq_pending_n};
        irq_d = !irq_pending_n;
    end
    // --------------------------------
    // read data
    // --------------------------------
    always_comb
    begin
        rdata_d = `UIE_RDATA_IDLE;
        rvalid_d = rd_ident || rd_en_reg;
        if (rd_ident)
        begin
            rdata_d = ident_q;
        end
        else if (rd_en_reg)
        begin
            rdata_d = {`UIE_RSVD_EN, en_q};
        end
    end
    // --------------------------------
    // enable and fifo control registers
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_q <= `UIE_EN_RESET;
            fctl_q <= `UIE_FCTL_RESET;
            fctl_wr_q <= 1'b0;
            fifo_on_status_q <= 1'b0;
        end
        else
        begin
            en_q <= en_d;
            fctl_q <= fctl_d;
            fctl_wr_q <= fctl_wr_d;
            fifo_on_status_q <= fifo_on_status_d;
        end
    end
    // --------------------------------
    // modem edge registers
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            modem_pend_q <= 1'b0;
            modem_prev_q <= '0;
        end
        else
        begin
            modem_pend_q <= modem_pend_d;
            modem_prev_q <= modem_prev_d;
        end
    end
    // --------------------------------
    // line error registers
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_pend_q <= 1'b0;
            line_prev_q <= 1'b0;
        end
        else
        begin
            line_pend_q <= line_pend_d;
            line_prev_q <= line_prev_d;
        end
    end
    // --------------------------------
    // transmit empty registers
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_pend_q <= 1'b0;
            tx_prev_q <= 1'b0;
        end
        else
        begin
            tx_pend_q <= tx_pend_d;
            tx_prev_q <= tx_prev_d;
        end
    end
    // --------------------------------
    // identification registers
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ident_q <= `UIE_IDENT_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            ident_q <= ident_d;
            irq_q <= irq_d;
        end
    end
    // --------------------------------
    // read data registers
    // --------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= `UIE_RDATA_IDLE;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end
    assign rdata = rdata_q;
    assign rdata_valid = rvalid_q;
    assign fifo_control_reg = fctl_q;
    assign fifo_ctl_wr = fctl_wr_q;
    assign irq = irq_q;
endmodule

// File: include/uie_consts.svh
// Contract
// - enable register at 0xC1, resets zero, bits 7:4 reserved, shares divisor-high address
// - enable bit 3 gates modem status edge interrupt; clear means never raised
// - enable bit 2 gates line error interrupt: parity, framing, overrun, break
// - enable bit 1 gates transmit empty interrupt, raised when transmit buffer becomes empty
// - enable bit 0 gates both receive data ready and receiver time-out interrupts
// - identification register read-only at 0xC2; writes there go to fifo control
// - ident bits 7:6 read 00 fifos off, 11 fifos on; 5:4 read zero
// - ident bits 3:1 give highest enabled source: line 011, data 010, timeout 110
// - transmit empty code 001 fourth; modem status code 000 lowest
// - pending line status interrupt clears on line status register read
// - modem interrupt set on any modem input change, cleared by modem status read
// - transmit empty interrupt drops on first holding register write after it rose
`ifndef UIE_CONSTS_SVH
`define UIE_CONSTS_SVH
`define UIE_ADDR_DIV_HIGH 8'hc1
`define UIE_ADDR_IDENT 8'hc2
`define UIE_ADDR_TX_HOLD 8'hc0
`define UIE_ADDR_LINE_STAT 8'hc5
`define UIE_ADDR_MODEM_STAT 8'hc6
`define UIE_EN_RESET 4'h0
`define UIE_EN_MODEM 3
`define UIE_EN_LINE 2
`define UIE_EN_TX 1
`define UIE_EN_RX 0
`define UIE_CODE_LINE 3'h3
`define UIE_CODE_RXDATA 3'h2
`define UIE_CODE_TIMEOUT 3'h6
`define UIE_CODE_TXEMPTY 3'h1
`define UIE_CODE_MODEM 3'h0
`define UIE_FIFO_ON 2'h3
`define UIE_FIFO_OFF 2'h0
`define UIE_RSVD_IDENT 2'h0
`define UIE_RSVD_EN 4'h0
`define UIE_IDENT_RESET 8'h01
`define UIE_FIFO_EN_BIT 0
`define UIE_MODEM_W 4
`define UIE_EN_MSB 3
`define UIE_FCTL_RESET 8'h00
`define UIE_RDATA_IDLE 8'h00
`endif

// File: include/uie_pkg.sv
package uie_pkg;
    typedef logic [7:0] uie_byte_t;
    typedef logic [2:0] uie_code_t;
endpackage

// File: logic/uie_sync.sv
`timescale 1ns/1ns
// --------------------------------
// two-flop synchroniser, one per bit
// --------------------------------
module uie_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                end
                else
                begin
                    s1_q[i] <= d[i];
                    s2_q[i] <= s1_q[i];
                end
            end
        end
    endgenerate
    assign q = s2_q;
endmodule

// File: verif/uie_core_props.sv
`timescale 1ns/1ns
// ----------------
// checker
// ----------------
module uie_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic dlab,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic [7:0] fifo_control_reg,
    input wire logic fifo_ctl_wr,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    id_read_a: assert property (rd_en && addr == 8'hc2 |=> rdata_valid)
        else $error("ident read lost");
    dlab_read_a: assert property (rd_en && addr == 8'hc1 && dlab |=> !rdata_valid)
        else $error("divisor read answered");
    fifo_wr_a: assert property (wr_en && addr == 8'hc2 |=>
        fifo_ctl_wr && fifo_control_reg == $past(wdata))
        else $error("fifo control write lost");
    wr_cause_a: assert property (fifo_ctl_wr |-> $past(wr_en) && $past(addr) == 8'hc2)
        else $error("stray fifo control pulse");
    rsvd_id_a: assert property (rdata_valid && $past(addr) == 8'hc2 |->
        rdata[5:4] == 2'b00)
        else $error("ident bits 5:4 set");
    fifo_sts_a: assert property (rdata_valid && $past(addr) == 8'hc2 |->
        rdata[7] == rdata[6])
        else $error("fifo status split");
    pend_bit_a: assert property (rdata_valid && $past(addr) == 8'hc2 |->
        rdata[0] == !$past(irq))
        else $error("pending bit disagrees with irq");
    rsvd_en_a: assert property (rdata_valid && $past(addr) == 8'hc1 |->
        rdata[7:4] == 4'h0)
        else $error("enable bits 7:4 set");
endmodule
bind uie_core uie_props u_props (.clk_sys, .rst_n, .addr, .wdata, .wr_en, .rd_en, .dlab,
    .rdata, .rdata_valid, .fifo_control_reg, .fifo_ctl_wr, .irq);

// File: verif/uie_cpu_model.sv
`timescale 1ns/1ns
// ----------------
// processor side
// ----------------
module uie_cpu_model (
    input wire logic clk_sys,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_en,
    output logic rd_en
);
    initial
    begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    // idle bus shows inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        wdata = d; // reserved bits as the caller gives
        wr_en = 1'b1;
        @(negedge clk_sys);
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk_sys);
        rd_en = 1'b0;
        addr = ~a;
        d = rdata;
    endtask
endmodule

// File: verif/test_uie_core.sv
`timescale 1ns/1ns
// ----------------
// testbench
// ----------------
module test_uie_core;
    import uie_pkg::*;
    logic clk_sys, rst_n, dlab, line_err, rx_ready, rx_timeout, tx_empty;
    logic [3:0] modem_in;
    logic [7:0] addr, wdata, rdata, fcr;
    logic wr_en, rd_en, rdata_valid, fifo_ctl_wr, irq;
    int bad_count, total_checks;
    uie_byte_t got;
    uie_byte_t en_t [4] = '{8'h08, 8'h02, 8'h01, 8'h04};
    uie_byte_t ex_t [4] = '{8'h00, 8'h02, 8'h04, 8'h06};
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    uie_core dut (.clk_sys, .rst_n, .addr, .wdata, .wr_en, .rd_en, .dlab, .line_err,
        .rx_ready, .rx_timeout, .tx_empty, .modem_in, .rdata, .rdata_valid,
        .fifo_control_reg(fcr), .fifo_ctl_wr, .irq);
    uie_cpu_model cpu (.clk_sys, .rdata, .addr, .wdata, .wr_en, .rd_en);
    task automatic cmp(input string n, input uie_byte_t e, input uie_byte_t g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd_chk(input uie_byte_t a, input uie_byte_t e);
        cpu.rd(a, got);
        cmp("reg", e, got);
    endtask
    task automatic id_chk(input uie_byte_t e);
        repeat (6) @(negedge clk_sys);
        rd_chk(8'hc2, e);
        cmp("irq", {7'h00, !e[0]}, {7'h00, irq});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #100000;
        bad_count++;
        stop_test();
    end
    initial
    begin
        rst_n = 1'b0;
        dlab = 1'b0;
        line_err = 1'b0;
        rx_ready = 1'b0;
        rx_timeout = 1'b0;
        tx_empty = 1'b0;
        modem_in = 4'h0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        rd_chk(8'hc1, 8'h00);
        id_chk(8'h01);
        cpu.wr(8'hc1, 8'hff);
        rd_chk(8'hc1, 8'h0f);
        cpu.wr(8'hc1, 8'h00);
        line_err = 1'b1;
        rx_ready = 1'b1;
        rx_timeout = 1'b1;
        tx_empty = 1'b1;
        modem_in = 4'h5;
        id_chk(8'h01);
        foreach (en_t[i])
        begin
            cpu.wr(8'hc1, en_t[i]);
            id_chk(ex_t[i]);
        end
        cpu.wr(8'hc1, 8'h0f);
        id_chk(8'h06);
        cpu.rd(8'hc5, got);
        id_chk(8'h04);
        rx_ready = 1'b0;
        id_chk(8'h0c);
        rx_timeout = 1'b0;
        id_chk(8'h02);
        cpu.wr(8'hc0, 8'h55);
        id_chk(8'h00);
        cpu.rd(8'hc6, got);
        id_chk(8'h01);
        modem_in = 4'h4;
        id_chk(8'h00);
        cpu.rd(8'hc6, got);
        cpu.wr(8'hc2, 8'h01);
        id_chk(8'hc1);
        cmp("fifo_ctl", 8'h01, fcr);
        tx_empty = 1'b0;
        id_chk(8'hc1);
        tx_empty = 1'b1;
        dlab = 1'b1;
        cpu.wr(8'hc0, 8'h00);
        id_chk(8'hc2);
        cpu.wr(8'hc1, 8'h00);
        dlab = 1'b0;
        rd_chk(8'hc1, 8'h0f);
        cpu.wr(8'hc2, 8'h00);
        id_chk(8'h02);
        stop_test();
    end
endmodule
